/* design/lpst_trigger.sv */
// Logic pattern and state trigger qualification with holdoff and auto mode.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Pattern: after holdoff, test all four inputs; trigger on function.
// - State: after holdoff, wait for channel four edge, then test function.
// - State uses channel four as clock; only three channels feed function.
// - AND all, NAND not all, OR any, NOR none; ignored inputs excluded.
// - Negated polarity swaps AND with NAND and OR with NOR.
// - Each channel has its own threshold deciding its logic level.
// - Clock event is channel four crossing its threshold with chosen slope.
// - Auto mode starts acquisition after a timeout derived from timebase.
// - Normal mode starts acquisition only on a valid trigger.
// - Holdoff is programmed as a percentage.
// - Pattern inputs each take high, low or ignored precondition.
// - State: three inputs high, low or ignored; clock rising or falling.
// - Time qualification applies only in pattern class.
// - Shorter-than needs true time below limit; longer-than above it.
// - Qualified: time true interval, trigger at its end if qualifier met.
module lpst_trigger
  import lpst_pkg::*;
(
  input  wire logic                                         i_clock,
  input  wire logic                                         i_rst,
  input  wire logic [LPST_CHANNELS-1:0][LPST_SAMPLE_W-1:0]  i_sample,
  input  wire logic [LPST_CHANNELS-1:0][LPST_SAMPLE_W-1:0]  i_threshold,
  input  wire lpst_class_t                                  i_class,
  input  wire lpst_func_t                                   i_func,
  input  wire logic                                         i_negate,
  input  wire lpst_pre_t [LPST_CHANNELS-1:0]                i_precondition,
  input  wire lpst_slope_t                                  i_clock_slope,
  input  wire lpst_qual_t                                   i_qualifier,
  input  wire logic [LPST_CNT_W-1:0]                        i_qual_cycles,
  input  wire lpst_mode_t                                   i_mode,
  input  wire logic [LPST_PCT_W-1:0]                        i_holdoff_pct,
  input  wire logic [LPST_TB_W-1:0]                         i_timebase_cycles,
  output logic                                              o_trigger,
  output logic                                              o_acquire_start,
  output logic                                              o_armed,
  output logic                                              o_holdoff_active,
  output logic [LPST_CHANNELS-1:0]                          o_levels
);
  lpst_level_if lvl_if [LPST_CHANNELS] ();
  logic [LPST_CHANNELS-1:0] level;

  for (genvar g = 0; g < LPST_CHANNELS; g++) begin : g_chan
    lpst_threshold u_thr (
      .i_clock     (i_clock),
      .i_rst       (i_rst),
      .i_sample    (i_sample[g]),
      .i_threshold (i_threshold[g]),
      .lvl         (lvl_if[g])
    );
    assign level[g] = lvl_if[g].level;
  end

  lpst_state_t             state;
  lpst_state_t             next_state;
  logic [LPST_CNT_W-1:0]   count;
  logic [LPST_CNT_W-1:0]   next_count;
  logic [LPST_CNT_W-1:0]   true_cnt;
  logic [LPST_CNT_W-1:0]   next_true_cnt;
  logic                    was_true;
  logic                    next_was_true;
  logic                    prev_clk;
  logic                    next_prev_clk;
  logic                    next_trigger;
  logic                    next_acquire;
  logic [LPST_CHANNELS-1:0] use_ch;
  logic [LPST_CHANNELS-1:0] hit;
  logic                    all_ok;
  logic                    any_ok;
  logic                    func_raw;
  logic                    cond;
  logic                    clk_edge;
  logic                    qualified;
  logic                    qual_ok;
  logic                    fire;
  logic                    auto_due;
  logic [LPST_PCT_W-1:0]   pct;
  logic [30:0]             hold_prod;
  logic [LPST_CNT_W-1:0]   holdoff_len;
  logic [LPST_CNT_W-1:0]   timeout_len;

  // Holdoff as percent of the timebase span.
  always_comb begin
    pct = (i_holdoff_pct > LPST_PCT_FULL) ? LPST_PCT_FULL : i_holdoff_pct;
    hold_prod = 31'(i_timebase_cycles) * 31'(pct);
    holdoff_len = 32'(hold_prod / LPST_PCT_DIV);
    if (holdoff_len == LPST_CNT_RESET) begin
      holdoff_len = LPST_CNT_ONE;
    end
    timeout_len = 32'(i_timebase_cycles) << LPST_AUTO_SHIFT;
    if (timeout_len == LPST_CNT_RESET) begin
      timeout_len = LPST_CNT_ONE;
    end
  end

  always_comb begin
    for (int i = 0; i < LPST_CHANNELS; i++) begin
      use_ch[i] = (i_precondition[i] != LPST_PRE_X);
      hit[i] = (i_precondition[i] == LPST_PRE_H) ? level[i] : ~level[i];
    end
    // Clock channel leaves the function in state class.
    if (i_class == LPST_CLASS_STATE) begin
      use_ch[LPST_CLOCK_CH] = 1'b0;
    end
    all_ok = &(~use_ch | hit);
    any_ok = |(use_ch & hit);
    case (i_func)
      LPST_FN_AND:  func_raw = all_ok;
      LPST_FN_NAND: func_raw = ~all_ok;
      LPST_FN_OR:   func_raw = any_ok;
      LPST_FN_NOR:  func_raw = ~any_ok;
      default:      func_raw = all_ok;
    endcase
    cond = func_raw ^ i_negate;
    if (i_clock_slope == LPST_SLOPE_RISE) begin
      clk_edge = level[LPST_CLOCK_CH] & ~prev_clk;
    end else begin
      clk_edge = ~level[LPST_CLOCK_CH] & prev_clk;
    end
    qualified = (i_class == LPST_CLASS_PATTERN)
                && (i_qualifier != LPST_QUAL_NONE);
    if (i_qualifier == LPST_QUAL_LESS) begin
      qual_ok = (true_cnt < i_qual_cycles);
    end else begin
      qual_ok = (true_cnt > i_qual_cycles);
    end
  end

  always_comb begin
    next_state    = state;
    next_count    = count;
    next_true_cnt = true_cnt;
    next_was_true = was_true;
    next_prev_clk = level[LPST_CLOCK_CH];
    next_trigger  = 1'b0;
    next_acquire  = 1'b0;
    fire          = 1'b0;
    auto_due      = 1'b0;
    case (state)
      LPST_ST_HOLDOFF: begin
        next_count = count + LPST_CNT_ONE;
        if (count + LPST_CNT_ONE >= holdoff_len) begin
          next_state    = LPST_ST_ARMED;
          next_count    = LPST_CNT_RESET;
          next_was_true = 1'b0;
          next_true_cnt = LPST_CNT_RESET;
        end
      end
      LPST_ST_ARMED: begin
        if (count != LPST_CNT_MAX) begin
          next_count = count + LPST_CNT_ONE;
        end
        if (i_class == LPST_CLASS_STATE) begin
          fire = clk_edge & cond;
        end else if (qualified) begin
          // Trigger where the true interval ends.
          fire = was_true & ~cond & qual_ok;
        end else begin
          fire = cond;
        end
        next_was_true = cond;
        if (cond) begin
          if (true_cnt != LPST_CNT_MAX) begin
            next_true_cnt = true_cnt + LPST_CNT_ONE;
          end
        end else begin
          next_true_cnt = LPST_CNT_RESET;
        end
        auto_due = (i_mode == LPST_MODE_AUTO)
                   && (count + LPST_CNT_ONE >= timeout_len);
        if (fire || auto_due) begin
          next_trigger = fire;
          next_acquire = 1'b1;
          next_state   = LPST_ST_HOLDOFF;
          next_count   = LPST_CNT_RESET;
        end
      end
      default: begin
        next_state = LPST_ST_HOLDOFF;
        next_count = LPST_CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state            <= LPST_ST_HOLDOFF;
      count            <= LPST_CNT_RESET;
      true_cnt         <= LPST_CNT_RESET;
      was_true         <= 1'b0;
      prev_clk         <= 1'b0;
      o_trigger        <= 1'b0;
      o_acquire_start  <= 1'b0;
      o_armed          <= 1'b0;
      o_holdoff_active <= 1'b1;
      o_levels         <= '0;
    end else begin
      state            <= next_state;
      count            <= next_count;
      true_cnt         <= next_true_cnt;
      was_true         <= next_was_true;
      prev_clk         <= next_prev_clk;
      o_trigger        <= next_trigger;
      o_acquire_start  <= next_acquire;
      o_armed          <= (next_state == LPST_ST_ARMED);
      o_holdoff_active <= (next_state == LPST_ST_HOLDOFF);
      o_levels         <= level;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_trig_armed;
    o_trigger |-> $past(o_armed);
  endproperty
  a_trig_armed: assert property (p_trig_armed)
    else $error("Trigger issued while not armed.");

  property p_holdoff_restart;
    o_trigger |-> o_holdoff_active && !o_armed ##1 !o_trigger;
  endproperty
  a_holdoff_restart: assert property (p_holdoff_restart)
    else $error("Holdoff not restarted after trigger.");

  property p_normal_only;
    (o_acquire_start && $past(i_mode) == LPST_MODE_NORMAL) |-> o_trigger;
  endproperty
  a_normal_only: assert property (p_normal_only)
    else $error("Normal mode acquired without trigger.");

  property p_state_edge;
    (o_trigger && $past(i_class) == LPST_CLASS_STATE)
      |-> $past(clk_edge) && $past(cond);
  endproperty
  a_state_edge: assert property (p_state_edge)
    else $error("State trigger without clock edge.");

  property p_slope;
    (o_trigger && $past(i_class) == LPST_CLASS_STATE
      && $past(i_clock_slope) == LPST_SLOPE_RISE)
      |-> $past(level[LPST_CLOCK_CH]) && !$past(prev_clk);
  endproperty
  a_slope: assert property (p_slope)
    else $error("Rising clock trigger without rising edge.");

  property p_pattern;
    (o_armed && i_class == LPST_CLASS_PATTERN
      && i_qualifier == LPST_QUAL_NONE && cond) |=> o_trigger;
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("Pattern condition met without trigger.");

  property p_qual_end;
    (o_trigger && $past(qualified)) |-> !$past(cond) && $past(was_true);
  endproperty
  a_qual_end: assert property (p_qual_end)
    else $error("Qualified trigger not at end of true interval.");

  property p_negate_and;
    (o_trigger && $past(i_class) == LPST_CLASS_PATTERN && !$past(qualified)
      && $past(i_func) == LPST_FN_AND && $past(i_negate)) |-> !$past(all_ok);
  endproperty
  a_negate_and: assert property (p_negate_and)
    else $error("Negated AND triggered while all preconditions held.");

  property p_auto;
    (o_armed && auto_due) |=> o_acquire_start && o_holdoff_active;
  endproperty
  a_auto: assert property (p_auto)
    else $error("Auto timeout did not start acquisition.");

  c_pattern: cover property (o_trigger
                             && $past(i_class) == LPST_CLASS_PATTERN);
  c_state:   cover property (o_trigger && $past(i_class) == LPST_CLASS_STATE);
  c_qual:    cover property (o_trigger && $past(qualified));
  c_auto:    cover property (o_acquire_start && !o_trigger);
endmodule : lpst_trigger
`default_nettype wire

/* inc/lpst_pkg.sv */
// Constants and types shared by the logic pattern and state trigger.
package lpst_pkg;
  localparam int unsigned LPST_CHANNELS = 4;
  localparam int unsigned LPST_SAMPLE_W = 8;
  localparam int unsigned LPST_TB_W     = 24;
  localparam int unsigned LPST_PCT_W    = 7;
  localparam int unsigned LPST_CNT_W    = 32;
  localparam int unsigned LPST_CLOCK_CH = 3;
  localparam logic [LPST_PCT_W-1:0] LPST_PCT_FULL   = 7'h64;
  localparam logic [30:0]           LPST_PCT_DIV    = 31'h0000_0064;
  localparam int unsigned           LPST_AUTO_SHIFT = 1;
  localparam logic [LPST_CNT_W-1:0] LPST_CNT_ONE    = 32'h0000_0001;
  localparam logic [LPST_CNT_W-1:0] LPST_CNT_RESET  = 32'h0000_0000;
  localparam logic [LPST_CNT_W-1:0] LPST_CNT_MAX    = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    LPST_PRE_X = 2'h0,
    LPST_PRE_H = 2'h1,
    LPST_PRE_L = 2'h2
  } lpst_pre_t;
  typedef enum logic [1:0] {
    LPST_FN_AND  = 2'h0,
    LPST_FN_NAND = 2'h1,
    LPST_FN_OR   = 2'h2,
    LPST_FN_NOR  = 2'h3
  } lpst_func_t;
  typedef enum logic {LPST_CLASS_PATTERN = 1'h0, LPST_CLASS_STATE = 1'h1}
    lpst_class_t;
  typedef enum logic [1:0] {
    LPST_QUAL_NONE = 2'h0,
    LPST_QUAL_LESS = 2'h1,
    LPST_QUAL_MORE = 2'h2
  } lpst_qual_t;
  typedef enum logic {LPST_SLOPE_RISE = 1'h0, LPST_SLOPE_FALL = 1'h1}
    lpst_slope_t;
  typedef enum logic {LPST_MODE_AUTO = 1'h0, LPST_MODE_NORMAL = 1'h1}
    lpst_mode_t;
  typedef enum logic {LPST_ST_HOLDOFF, LPST_ST_ARMED} lpst_state_t;
endpackage : lpst_pkg

/* inc/lpst_level_if.sv */
// Carries one thresholded channel level between the design modules.
`timescale 1ns/1ns
`default_nettype none
interface lpst_level_if;
  logic level;
  modport drive (output level);
  modport take  (input level);
endinterface : lpst_level_if
`default_nettype wire

/* design/lpst_threshold.sv */
// One channel comparator against its own threshold.
`timescale 1ns/1ns
`default_nettype none
module lpst_threshold
  import lpst_pkg::*;
(
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  input  wire logic [LPST_SAMPLE_W-1:0] i_sample,
  input  wire logic [LPST_SAMPLE_W-1:0] i_threshold,
  lpst_level_if.drive                   lvl
);
  logic next_level;

  always_comb begin
    next_level = (i_sample >= i_threshold);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lvl.level <= 1'b0;
    end else begin
      lvl.level <= next_level;
    end
  end
endmodule : lpst_threshold
`default_nettype wire

/* bench/lpst_channel_model.sv */
// Model of the four thresholded analog input channels.
`timescale 1ns/1ns
`default_nettype none
module lpst_channel_model
  import lpst_pkg::*;
(
  input  wire logic [LPST_CHANNELS-1:0]                    i_high,
  input  wire logic [LPST_CHANNELS-1:0][LPST_SAMPLE_W-1:0] i_threshold,
  output logic      [LPST_CHANNELS-1:0][LPST_SAMPLE_W-1:0] o_sample
);
  // Own threshold each.
  // A high channel sits exactly on its threshold, a low one just under it.
  always_comb begin
    for (int c = 0; c < LPST_CHANNELS; c++) begin
      o_sample[c] = i_high[c] ? i_threshold[c] : i_threshold[c] - 8'h01;
    end
  end
endmodule : lpst_channel_model
`default_nettype wire

/* bench/lpst_trigger_bench.sv */
// Self-checking bench for the logic pattern and state trigger.
`timescale 1ns/1ns
`default_nettype none
module lpst_trigger_bench;
  import lpst_pkg::*;
  typedef logic [LPST_CHANNELS-1:0][LPST_SAMPLE_W-1:0] lpst_bus_t;
  logic                     i_clock = 1'b0;
  logic                     i_rst   = 1'b1;
  logic [3:0]               high    = 4'h0;
  lpst_bus_t                thr     = {8'hC0, 8'h80, 8'h40, 8'h10};
  lpst_bus_t                smp;
  lpst_class_t              cls     = LPST_CLASS_PATTERN;
  lpst_func_t               fn      = LPST_FN_AND;
  logic                     neg     = 1'b0;
  lpst_pre_t [3:0]          pre     = {LPST_PRE_H, LPST_PRE_X, LPST_PRE_L,
                                       LPST_PRE_H};
  lpst_slope_t              slope   = LPST_SLOPE_RISE;
  lpst_qual_t               qual    = LPST_QUAL_NONE;
  logic [LPST_CNT_W-1:0]    lim     = 32'h0000_0005;
  lpst_mode_t               mode    = LPST_MODE_NORMAL;
  logic [LPST_PCT_W-1:0]    pct     = 7'h32;
  logic [LPST_TB_W-1:0]     tbase   = 24'h00_0008;
  logic                     trig, acq, armed, hold;
  logic [3:0]               lvl;
  int                       num_errors = 0;
  int                       samples_checked = 0;
  int                       at_t, at_a, n;
  lpst_qual_t               qq [6] = '{LPST_QUAL_LESS, LPST_QUAL_LESS,
    LPST_QUAL_LESS, LPST_QUAL_MORE, LPST_QUAL_MORE, LPST_QUAL_MORE};
  int                       ql [6] = '{3, 5, 9, 3, 5, 9};
  logic                     qe [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [4:0]               st [6] = '{5'h05, 5'h0A, 5'h0C, 5'h1D, 5'h12,
                                       5'h03};

  always #10 i_clock = ~i_clock;

  lpst_channel_model model (.i_high(high), .i_threshold(thr), .o_sample(smp));
  lpst_trigger DUT (.i_clock(i_clock), .i_rst(i_rst), .i_sample(smp),
    .i_threshold(thr), .i_class(cls), .i_func(fn), .i_negate(neg),
    .i_precondition(pre), .i_clock_slope(slope), .i_qualifier(qual),
    .i_qual_cycles(lim), .i_mode(mode), .i_holdoff_pct(pct),
    .i_timebase_cycles(tbase), .o_trigger(trig), .o_acquire_start(acq),
    .o_armed(armed), .o_holdoff_active(hold), .o_levels(lvl));

  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic step;
    @(negedge i_clock);
  endtask : step

  task automatic wait_armed;
    for (n = 0; n < 300 && armed !== 1'b1; n++) step();
    if (n == 300) begin
      chk("armed wait", 1, 0);
      final_report();
    end
  endtask : wait_armed

  // Records the cycle of the first trigger pulse and the first acquire pulse within the given span.
  task automatic watch(input int len);
    at_t = -1;
    at_a = -1;
    for (int i = 0; i < len; i++) begin
      step();
      if (trig === 1'b1 && at_t < 0) at_t = i;
      if (acq === 1'b1 && at_a < 0) at_a = i;
    end
  endtask : watch

  task automatic do_reset;
    i_rst = 1'b1;
    repeat (6) step();
    chk("reset outputs", 8'h10, {trig, acq, armed, hold, lvl});
    i_rst = 1'b0;
  endtask : do_reset

  function automatic logic efn(input int nch);
    int sel, hit;
    logic r;
    sel = 0;
    hit = 0;
    for (int c = 0; c < nch; c++) begin
      if (pre[c] != LPST_PRE_X) begin
        sel++;
        if (high[c] == (pre[c] == LPST_PRE_H)) hit++;
      end
    end
    case (fn)
      LPST_FN_AND:  r = (hit == sel);
      LPST_FN_NAND: r = (hit != sel);
      LPST_FN_OR:   r = (hit > 0);
      default:      r = (hit == 0);
    endcase
    return r ^ neg;
  endfunction : efn

  task automatic run(input logic [3:0] lv);
    logic exp;
    high = lv;
    exp = efn(4);
    wait_armed();
    watch(6);
    chk("pattern trigger", exp, at_t >= 0);
    chk("levels", lv, lvl);
  endtask : run

  task automatic holdoff(input logic [6:0] p, input int exp);
    int cnt;
    logic bad;
    pct = p;
    high = 4'h9;
    do_reset();
    cnt = 0;
    bad = 1'b0;
    for (n = 0; n < 300 && trig !== 1'b1; n++) step();
    if (n == 300) begin
      chk("trigger wait", 1, 0);
      final_report();
    end
    while (hold === 1'b1 && cnt < 300) begin
      cnt++;
      bad |= (trig === 1'b1 && cnt > 1);
      step();
    end
    chk("holdoff cycles", exp, cnt);
    chk("trigger in holdoff", 0, bad);
  endtask : holdoff

  initial begin
    do_reset();
    holdoff(7'h00, 1);
    holdoff(7'h32, 4);
    holdoff(7'h64, 8);
    holdoff(7'h7F, 8);
    for (int f = 0; f < 4; f++) begin
      for (int g = 0; g < 2; g++) begin
        fn = lpst_func_t'(f);
        neg = g[0];
        high = 4'h0;
        do_reset();
        for (int v = 0; v < 16; v++) run(v[3:0]);
      end
    end
    fn = LPST_FN_AND;
    neg = 1'b0;
    mode = LPST_MODE_AUTO;
    high = 4'h0;
    do_reset();
    wait_armed();
    for (n = 0; n < 100 && acq !== 1'b1; n++) step();
    chk("auto timeout", 32'(tbase) << 1, n);
    chk("auto start", 2'h2, {acq, trig});
    if (n == 100) begin
      final_report();
    end
    mode = LPST_MODE_NORMAL;
    do_reset();
    wait_armed();
    watch(60);
    chk("normal start", 32'hFFFF_FFFF, at_a);
    pre = {LPST_PRE_X, LPST_PRE_X, LPST_PRE_X, LPST_PRE_H};
    for (int k = 0; k < 6; k++) begin
      qual = qq[k];
      high = 4'h0;
      do_reset();
      wait_armed();
      step();
      high = 4'h1;
      watch(ql[k]);
      chk("early trigger", 32'hFFFF_FFFF, at_t);
      high = 4'h0;
      watch(6);
      chk("qualified trigger", qe[k], at_t >= 0);
    end
    cls = LPST_CLASS_STATE;
    qual = LPST_QUAL_MORE;
    pre = {LPST_PRE_L, LPST_PRE_X, LPST_PRE_X, LPST_PRE_H};
    for (int k = 0; k < 6; k++) begin
      slope = lpst_slope_t'(st[k][4]);
      neg = st[k][1];
      high = {st[k][3], 2'h0, st[k][2]};
      do_reset();
      wait_armed();
      watch(6);
      chk("no clock edge", 32'hFFFF_FFFF, at_t);
      high[3] = ~st[k][3];
      watch(6);
      chk("state trigger", st[k][0],
          at_t >= 0);
    end
    final_report();
  end
endmodule : lpst_trigger_bench
`default_nettype wire
